// ---- pkg/flow_msg_pkg.sv ----
package flow_msg_pkg;

   // ************************************************************
   // message tags and sizes
   // ************************************************************
   localparam logic [23:0] OPEN_CNF_TAG = 24'h9f8e01;
   localparam logic [23:0] DELETE_REQ_TAG = 24'h9f8e02;
   localparam logic [23:0] DELETE_CNF_TAG = 24'h9f8e03;
   localparam int OPT_BYTES = 8;
   localparam int MSG_BYTES = 18 + OPT_BYTES;
   localparam logic [7:0] HEAD_BYTES = 8'h04;
   localparam logic [7:0] BODY_DENIED = 8'h02;
   localparam logic [7:0] BODY_GRANTED = 8'h06;
   localparam logic [7:0] BODY_IP = 8'h0e;
   localparam logic [7:0] BODY_DELETE = 8'h04;

   // ************************************************************
   // open confirmation status codes
   // ************************************************************
   localparam logic [7:0] CNF_GRANTED = 8'h00;
   localparam logic [7:0] CNF_TOO_MANY = 8'h01;
   localparam logic [7:0] CNF_NO_SERVICE = 8'h02;
   localparam logic [7:0] CNF_NET_DOWN = 8'h03;
   localparam logic [7:0] CNF_NET_BUSY = 8'h04;
   localparam logic [7:0] CNF_MAC_REFUSED = 8'h05;

   // ************************************************************
   // delete confirmation status codes
   // ************************************************************
   localparam logic [7:0] DEL_DONE = 8'h00;
   localparam logic [7:0] DEL_NET_DOWN = 8'h03;
   localparam logic [7:0] DEL_NET_BUSY = 8'h04;
   localparam logic [7:0] DEL_UNKNOWN = 8'h05;
   localparam logic [7:0] DEL_NOT_ALLOWED = 8'h06;

   // ************************************************************
   // flow fields
   // ************************************************************
   localparam logic [7:0] IP_UNICAST_SERVICE = 8'h00;
   localparam logic [7:0] FT_UDP_TCP = 8'h00;
   localparam logic [7:0] FT_UDP_ONLY = 8'h01;
   localparam logic [7:0] FT_TCP_ONLY = 8'h02;
   localparam logic [1:0] FLAGS_RSVD = 2'b00;
   localparam logic [23:0] FIRST_FLOW_IDENTIFIER = 24'h000001;
   localparam logic [23:0] LAST_FLOW_IDENTIFIER = 24'hffffff;
   localparam logic [7:0] OPT_PAD = 8'h00;
   localparam logic [7:0] OPT_END = 8'hff;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [7:0] service_type;
   } open_req_t;

   typedef struct packed {
      logic [23:0] flow_identifier;
   } delete_req_t;

   typedef struct packed {
      logic [7:0] status;
      logic [31:0] assigned_ip;
      logic [7:0] flow_type;
      logic no_frag;
      logic [12:0] max_pdu;
      logic [7:0] opt_len;
      logic [OPT_BYTES*8-1:0] options;
   } net_answer_t;

endpackage

// ---- core/byte_stream_tx.sv ----
`timescale 1ns/10ps
module byte_stream_tx #(
   parameter int NBYTES = 26
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // message load
   input wire logic load,
   input wire logic [NBYTES*8-1:0] msg,
   input wire logic [7:0] count,
   // byte stream
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   input wire logic tx_ready,
   // status
   output logic busy
);

   logic [NBYTES*8-1:0] buf_reg;
   logic [7:0] remain_reg;
   logic [7:0] data_reg;
   logic valid_reg;
   logic last_reg;

   // first byte sits in the top lane; shifting keeps the next one there
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_reg <= '0;
         remain_reg <= 8'h00;
         data_reg <= 8'h00;
         valid_reg <= 1'b0;
         last_reg <= 1'b0;
      end else if (load) begin
         buf_reg <= msg << 8;
         data_reg <= msg[NBYTES*8-1 -: 8];
         remain_reg <= count;
         valid_reg <= count != 8'h00;
         last_reg <= count == 8'h01;
      end else if (valid_reg && tx_ready) begin
         if (remain_reg == 8'h01) begin
            valid_reg <= 1'b0;
         end
         data_reg <= buf_reg[NBYTES*8-1 -: 8];
         buf_reg <= buf_reg << 8;
         remain_reg <= remain_reg - 8'h01;
         last_reg <= remain_reg == 8'h02;
      end
   end

   assign tx_valid = valid_reg;
   assign tx_data = data_reg;
   assign tx_last = last_reg;
   assign busy = valid_reg;

endmodule

// ---- core/flow_msg_handler.sv ----
`timescale 1ns/10ps
module flow_msg_handler #(
   parameter int MAX_FLOWS = 4,
   parameter logic [7:0] SERVICE_MASK = 8'hff
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // decoded open requests
   input wire logic open_valid,
   input wire flow_msg_pkg::open_req_t open_req,
   output logic open_ready,
   // decoded deletion requests
   input wire logic del_valid,
   input wire flow_msg_pkg::delete_req_t del_req,
   output logic del_ready,
   // network side
   input wire logic net_up,
   output logic net_open_req,
   output logic [7:0] net_open_service,
   input wire logic ans_valid,
   input wire flow_msg_pkg::net_answer_t ans,
   output logic ans_ready,
   // confirmation byte stream
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   input wire logic tx_ready,
   // status
   output logic open_pending
);
   import flow_msg_pkg::*;

   localparam int SLOT_W = $clog2(MAX_FLOWS);
   localparam int CNT_W = $clog2(MAX_FLOWS + 1);

   logic ans_ready_reg;
   logic del_ready_reg;
   logic open_ready_reg;
   logic pending_reg;
   logic [7:0] pend_service_reg;
   logic net_open_req_reg;
   logic [23:0] next_id_reg;
   logic [MAX_FLOWS-1:0] slot_used_reg;
   logic [23:0] slot_id_reg [MAX_FLOWS];
   logic take_ans;
   logic take_del;
   logic take_open;
   logic forward;
   logic load;
   logic ser_busy;
   logic any_grant;
   logic [SLOT_W-1:0] free_slot;
   logic [SLOT_W-1:0] hit_slot;
   logic [CNT_W-1:0] free_cnt;
   logic hit;
   logic svc_ok;
   logic granted;
   logic ip_flow;
   logic [7:0] open_status;
   logic [7:0] del_status;
   logic [7:0] left;
   logic [7:0] opt_len;
   logic [7:0] flow_kind;
   logic [7:0] body_len;
   logic [7:0] msg_len;
   logic [MSG_BYTES*8-1:0] msg;

   // ************************************************************
   // option sanitising
   // ************************************************************
   // walks code/length/data; an end code and all after it become pad,
   // so the byte count promised in the length field still holds
   function automatic logic [OPT_BYTES*8-1:0] clean_options(
      input logic [OPT_BYTES*8-1:0] raw);
      logic [7:0] b;
      logic [7:0] remain;
      logic want_len;
      logic ended;
      logic [OPT_BYTES*8-1:0] res;
      remain = 8'h00;
      want_len = 1'b0;
      ended = 1'b0;
      res = '0;
      for (int i = 0; i < OPT_BYTES; i++) begin
         b = raw[(OPT_BYTES-1-i)*8 +: 8];
         if (ended) begin
            b = OPT_PAD;
         end else if (want_len) begin
            remain = b;
            want_len = 1'b0;
         end else if (remain != 8'h00) begin
            remain = remain - 8'h01;
         end else if (b == OPT_END) begin
            ended = 1'b1;
            b = OPT_PAD;
         end else if (b != OPT_PAD) begin
            want_len = 1'b1;
         end
         res[(OPT_BYTES-1-i)*8 +: 8] = b;
      end
      return res;
   endfunction

   // ************************************************************
   // flow table scan
   // ************************************************************
   always_comb begin
      free_slot = '0;
      hit_slot = '0;
      hit = 1'b0;
      free_cnt = '0;
      for (int i = MAX_FLOWS - 1; i >= 0; i--) begin
         if (!slot_used_reg[i]) begin
            free_slot = SLOT_W'(i);
            free_cnt = free_cnt + CNT_W'(1);
         end
         if (slot_used_reg[i] &&
             slot_id_reg[i] == del_req.flow_identifier) begin
            hit = 1'b1;
            hit_slot = SLOT_W'(i);
         end
      end
   end

   // ************************************************************
   // request decisions
   // ************************************************************
   assign svc_ok = open_req.service_type < 8'h08 &&
                   SERVICE_MASK[open_req.service_type[2:0]];
   // the flow being asked for takes one of the free slots
   assign left = (free_cnt == '0) ? 8'h00 : 8'(free_cnt) - 8'h01;

   always_comb begin
      if (pending_reg) begin
         open_status = CNF_NET_BUSY;
      end else if (free_cnt == '0) begin
         open_status = CNF_TOO_MANY;
      end else if (!svc_ok) begin
         open_status = CNF_NO_SERVICE;
      end else if (!net_up) begin
         open_status = CNF_NET_DOWN;
      end else begin
         open_status = CNF_GRANTED;
      end
   end

   always_comb begin
      if (!net_up) begin
         del_status = DEL_NET_DOWN;
      end else if (hit) begin
         del_status = DEL_DONE;
      end else begin
         del_status = DEL_UNKNOWN;
      end
   end

   assign take_ans = ans_valid && ans_ready_reg;
   assign take_del = del_valid && del_ready_reg;
   assign take_open = open_valid && open_ready_reg;
   assign forward = take_open && open_status == CNF_GRANTED;
   assign granted = ans.status == CNF_GRANTED;
   assign ip_flow = pend_service_reg == IP_UNICAST_SERVICE;
   assign opt_len = (ans.opt_len > 8'(OPT_BYTES)) ? 8'(OPT_BYTES) :
                    ans.opt_len;
   assign flow_kind = (ans.flow_type > FT_TCP_ONLY) ? FT_UDP_TCP :
                      ans.flow_type;
   // an answer with nothing pending is dropped without a message
   assign load = take_del || (take_ans && pending_reg) ||
                 (take_open && !forward);

   always_comb begin
      if (!granted) begin
         body_len = BODY_DENIED;
      end else if (!ip_flow) begin
         body_len = BODY_GRANTED;
      end else begin
         body_len = BODY_IP + opt_len;
      end
   end

   // ************************************************************
   // message assembly
   // ************************************************************
   always_comb begin
      if (take_del) begin
         msg = {DELETE_CNF_TAG, BODY_DELETE, del_req.flow_identifier,
                del_status, {(MSG_BYTES-8)*8{1'b0}}};
         msg_len = HEAD_BYTES + BODY_DELETE;
      end else if (take_ans) begin
         msg = {OPEN_CNF_TAG, body_len, ans.status, left, next_id_reg,
                pend_service_reg, ans.assigned_ip, flow_kind, FLAGS_RSVD,
                ans.no_frag, ans.max_pdu, opt_len,
                clean_options(ans.options)};
         msg_len = HEAD_BYTES + body_len;
      end else begin
         msg = {OPEN_CNF_TAG, BODY_DENIED, open_status, left,
                {(MSG_BYTES-6)*8{1'b0}}};
         msg_len = HEAD_BYTES + BODY_DENIED;
      end
   end

   // ************************************************************
   // request grants
   // ************************************************************
   // one source per message; answers first so a pending open drains
   assign any_grant = ans_ready_reg || del_ready_reg || open_ready_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ans_ready_reg <= 1'b0;
         del_ready_reg <= 1'b0;
         open_ready_reg <= 1'b0;
      end else begin
         ans_ready_reg <= 1'b0;
         del_ready_reg <= 1'b0;
         open_ready_reg <= 1'b0;
         if (!any_grant && !ser_busy) begin
            if (ans_valid) begin
               ans_ready_reg <= 1'b1;
            end else if (del_valid) begin
               del_ready_reg <= 1'b1;
            end else if (open_valid) begin
               open_ready_reg <= 1'b1;
            end
         end
      end
   end

   // ************************************************************
   // pending open request
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_reg <= 1'b0;
         pend_service_reg <= 8'h00;
         net_open_req_reg <= 1'b0;
      end else begin
         net_open_req_reg <= forward;
         if (forward) begin
            pending_reg <= 1'b1;
            pend_service_reg <= open_req.service_type;
         end else if (take_ans) begin
            pending_reg <= 1'b0;
         end
      end
   end

   // ************************************************************
   // flow table and identifiers
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         next_id_reg <= FIRST_FLOW_IDENTIFIER;
      end else if (take_ans && pending_reg && granted) begin
         next_id_reg <= (next_id_reg == LAST_FLOW_IDENTIFIER) ? FIRST_FLOW_IDENTIFIER :
                        next_id_reg + 24'h000001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_used_reg <= '0;
         for (int i = 0; i < MAX_FLOWS; i++) begin
            slot_id_reg[i] <= 24'h000000;
         end
      end else if (take_ans && pending_reg && granted) begin
         slot_used_reg[free_slot] <= 1'b1;
         slot_id_reg[free_slot] <= next_id_reg;
      end else if (take_del && net_up && hit) begin
         slot_used_reg[hit_slot] <= 1'b0;
      end
   end

   // ************************************************************
   // confirmation output
   // ************************************************************
   byte_stream_tx #(
      .NBYTES(MSG_BYTES)
   ) u_tx (
      .clk(clk),
      .rst_n(rst_n),
      .load(load),
      .msg(msg),
      .count(msg_len),
      .tx_valid(tx_valid),
      .tx_data(tx_data),
      .tx_last(tx_last),
      .tx_ready(tx_ready),
      .busy(ser_busy)
   );

   assign open_ready = open_ready_reg;
   assign del_ready = del_ready_reg;
   assign ans_ready = ans_ready_reg;
   assign net_open_req = net_open_req_reg;
   assign net_open_service = pend_service_reg;
   assign open_pending = pending_reg;

endmodule

// ---- verification/flow_msg_chk.sv ----
`timescale 1ns/10ps
module flow_msg_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // request handshakes
   input wire logic open_valid,
   input wire logic open_ready,
   input wire logic del_valid,
   input wire logic del_ready,
   input wire logic ans_valid,
   input wire logic ans_ready,
   // network side
   input wire logic net_open_req,
   input wire logic [7:0] net_open_service,
   input wire logic open_pending,
   // confirmation stream
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_open_take; open_valid && open_ready; endsequence
   sequence s_del_take; del_valid && del_ready; endsequence
   sequence s_head; tx_valid && tx_data == 8'h9f; endsequence
   property p_busy; s_open_take ##0 open_pending |=> s_head; endproperty
   property p_open;
      s_open_take |=> (tx_valid && tx_data == 8'h9f) || net_open_req;
   endproperty
   property p_del; s_del_take |=> s_head; endproperty
   property p_ans;
      ans_valid && ans_ready && open_pending |=> s_head ##0 !open_pending;
   endproperty
   property p_start; $rose(tx_valid) |-> tx_data == 8'h9f; endproperty
   property p_hold;
      tx_valid && !tx_ready |=>
         tx_valid && $stable(tx_data) && $stable(tx_last);
   endproperty
   property p_end; tx_valid && tx_ready && tx_last |=> !tx_valid; endproperty
   property p_quiet; tx_valid |-> !open_ready && !del_ready && !ans_ready;
   endproperty
   property p_keep;
      open_pending && $past(open_pending) |-> $stable(net_open_service);
   endproperty
   property p_fwd; net_open_req |=> !net_open_req && open_pending; endproperty
   a_busy: assert property (p_busy)
      else $error("open while pending not answered");
   a_open: assert property (p_open)
      else $error("open neither answered nor forwarded");
   a_del: assert property (p_del)
      else $error("delete not answered");
   a_ans: assert property (p_ans)
      else $error("network answer not confirmed");
   a_start: assert property (p_start)
      else $error("message does not open with tag");
   a_hold: assert property (p_hold)
      else $error("byte changed while stalled");
   a_end: assert property (p_end)
      else $error("stream runs past last byte");
   a_quiet: assert property (p_quiet)
      else $error("grant while streaming");
   a_keep: assert property (p_keep)
      else $error("pending service changed");
   a_fwd: assert property (p_fwd)
      else $error("forward pulse wrong");
endmodule
bind flow_msg_handler flow_msg_chk u_chk (
   .clk(clk), .rst_n(rst_n), .open_valid(open_valid),
   .open_ready(open_ready), .del_valid(del_valid), .del_ready(del_ready),
   .ans_valid(ans_valid), .ans_ready(ans_ready),
   .net_open_req(net_open_req), .net_open_service(net_open_service),
   .open_pending(open_pending), .tx_valid(tx_valid), .tx_data(tx_data),
   .tx_last(tx_last), .tx_ready(tx_ready)
);

// ---- verification/flow_net_model.sv ----
`timescale 1ns/10ps
module flow_net_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // set up by the bench
   input wire flow_msg_pkg::net_answer_t answer,
   input wire logic [7:0] delay,
   input wire logic stall,
   // handler side
   input wire logic net_open_req,
   input wire logic ans_ready,
   output flow_msg_pkg::net_answer_t ans,
   output logic ans_valid,
   output logic tx_ready
);
   import flow_msg_pkg::*;
   logic [7:0] wait_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ans_valid <= 1'b0;
         ans <= '0;
         wait_reg <= 8'h00;
         tx_ready <= 1'b0;
      end else begin
         // a stalling sink drops ready every other cycle
         tx_ready <= stall ? ~tx_ready : 1'b1;
         // idle answer lines toggle so stale data is never trusted
         if (!ans_valid) ans <= ~ans;
         if (ans_valid && ans_ready) begin
            ans_valid <= 1'b0;
            ans <= ~ans;
         end else if (net_open_req) begin
            wait_reg <= delay;
         end else if (wait_reg == 8'h01) begin
            ans_valid <= 1'b1;
            ans <= answer;
            wait_reg <= 8'h00;
         end else if (wait_reg != 8'h00) begin
            wait_reg <= wait_reg - 8'h01;
         end
      end
   end
endmodule

// ---- verification/test_data_flow_setup_message_handler.sv ----
`timescale 1ns/10ps
module test_data_flow_setup_message_handler;
   import flow_msg_pkg::*;
   localparam int SLOTS = 4;
   logic clk, rst_n, open_valid, del_valid, net_up, stall;
   logic open_ready, del_ready, net_open_req, ans_valid, ans_ready;
   logic tx_valid, tx_last, tx_ready, open_pending;
   logic [7:0] net_open_service, tx_data, delay;
   open_req_t open_req;
   delete_req_t del_req;
   net_answer_t ans, answer;
   logic [7:0] got_q[$], exp_q[$];
   logic last_q[$];
   int error_cnt = 0;
   int checks_done = 0;
   flow_msg_handler #(.MAX_FLOWS(SLOTS), .SERVICE_MASK(8'hff)) dut (
      .clk(clk), .rst_n(rst_n), .open_valid(open_valid),
      .open_req(open_req), .open_ready(open_ready), .del_valid(del_valid),
      .del_req(del_req), .del_ready(del_ready), .net_up(net_up),
      .net_open_req(net_open_req), .net_open_service(net_open_service),
      .ans_valid(ans_valid), .ans(ans), .ans_ready(ans_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
      .tx_ready(tx_ready), .open_pending(open_pending));
   flow_net_model net (
      .clk(clk), .rst_n(rst_n), .answer(answer), .delay(delay),
      .stall(stall), .net_open_req(net_open_req), .ans_ready(ans_ready),
      .ans(ans), .ans_valid(ans_valid), .tx_ready(tx_ready));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         got_q.push_back(tx_data);
         last_q.push_back(tx_last);
      end
   end
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task send(input logic is_del, input logic [23:0] v, input logic up);
      int i;
      logic seen;
      seen = 1'b0;
      @(posedge clk);
      net_up <= up;
      if (is_del) begin
         del_valid <= 1'b1;
         del_req.flow_identifier <= v;
      end else begin
         open_valid <= 1'b1;
         open_req.service_type <= v[7:0];
      end
      for (i = 0; i < 200 && !seen; i++) begin
         @(posedge clk);
         #1;
         seen = is_del ? del_ready === 1'b1 : open_ready === 1'b1;
      end
      if (!seen) begin
         error_cnt++;
         conclude();
      end
      @(posedge clk);
      open_valid <= 1'b0;
      del_valid <= 1'b0;
   endtask
   task expect_msg;
      int i;
      int k;
      for (i = 0; i < 400 && got_q.size() < exp_q.size(); i++) @(posedge clk);
      if (got_q.size() < exp_q.size()) begin
         error_cnt++;
         conclude();
      end
      repeat (3) @(posedge clk);
      check(8'(got_q.size()), 8'(exp_q.size()));
      for (k = 0; k < exp_q.size(); k++) begin
         check(got_q[k], exp_q[k]);
         check({7'h00, last_q[k]}, {7'h00, k == exp_q.size() - 1});
      end
      got_q.delete();
      last_q.delete();
   endtask
   task t_local_deny;
      send(1'b0, 24'h000001, 1'b0);
      exp_q = {8'h9f, 8'h8e, 8'h01, BODY_DENIED, CNF_NET_DOWN, 8'(SLOTS-1)};
      expect_msg();
      send(1'b0, 24'h000008, 1'b1);
      exp_q = {8'h9f, 8'h8e, 8'h01, BODY_DENIED, CNF_NO_SERVICE, 8'(SLOTS-1)};
      expect_msg();
   endtask
   task t_grant_ip;
      int i;
      @(posedge clk);
      answer <= '{status: CNF_GRANTED, assigned_ip: 32'hc0a80a07,
         flow_type: 8'h05, no_frag: 1'b1, max_pdu: 13'h05dc,
         opt_len: 8'h04, options: 64'h030105ff_00000000};
      delay <= 8'd40;
      stall <= 1'b1;
      send(1'b0, 24'(IP_UNICAST_SERVICE), 1'b1);
      for (i = 0; i < 20 && open_pending !== 1'b1; i++) @(posedge clk);
      #1;
      check(net_open_service, IP_UNICAST_SERVICE);
      check({7'h00, open_pending}, 8'h01);
      send(1'b0, 24'(IP_UNICAST_SERVICE), 1'b1);
      exp_q = {8'h9f, 8'h8e, 8'h01, BODY_DENIED, CNF_NET_BUSY, 8'(SLOTS-1)};
      expect_msg();
      exp_q = {8'h9f, 8'h8e, 8'h01, BODY_IP + 8'h04, CNF_GRANTED,
         8'(SLOTS-1), 8'h00, 8'h00, 8'h01, IP_UNICAST_SERVICE, 8'hc0, 8'ha8,
         8'h0a, 8'h07, FT_UDP_TCP, 8'h25, 8'hdc, 8'h04, 8'h03, 8'h01, 8'h05,
         OPT_PAD};
      expect_msg();
   endtask
   task t_grant_plain;
      int s;
      @(posedge clk);
      answer.status <= CNF_GRANTED;
      delay <= 8'd3;
      stall <= 1'b0;
      send(1'b0, 24'h000003, 1'b1);
      exp_q = {8'h9f, 8'h8e, 8'h01, BODY_GRANTED, CNF_GRANTED, 8'(SLOTS-2),
         8'h00, 8'h00, 8'h02, 8'h03};
      expect_msg();
      for (s = 1; s <= 5; s++) begin
         @(posedge clk);
         answer.status <= 8'(s);
         send(1'b0, 24'h000001, 1'b1);
         exp_q = {8'h9f, 8'h8e, 8'h01, BODY_DENIED, 8'(s), 8'(SLOTS-3)};
         expect_msg();
      end
   endtask
   task del_case(input logic [23:0] id, input logic up, input logic [7:0] st);
      send(1'b1, id, up);
      exp_q = {8'h9f, 8'h8e, DELETE_CNF_TAG[7:0], BODY_DELETE, id[23:16],
         id[15:8], id[7:0], st};
      expect_msg();
   endtask
   task t_delete;
      del_case(24'h000001, 1'b1, DEL_DONE);
      del_case(24'h000001, 1'b1, DEL_UNKNOWN);
      del_case(24'h000002, 1'b0, DEL_NET_DOWN);
   endtask
   // fills the table from one live flow, then the next open must be
   // refused locally with no further flows left
   task t_table_full;
      int s;
      @(posedge clk);
      answer.status <= CNF_GRANTED;
      for (s = 0; s < SLOTS - 1; s++) begin
         send(1'b0, 24'h000003, 1'b1);
         exp_q = {8'h9f, 8'h8e, 8'h01, BODY_GRANTED, CNF_GRANTED,
            8'(SLOTS-2-s), 8'h00, 8'h00, 8'(3+s), 8'h03};
         expect_msg();
      end
      send(1'b0, 24'h000003, 1'b1);
      exp_q = {8'h9f, 8'h8e, 8'h01, BODY_DENIED, CNF_TOO_MANY, 8'h00};
      expect_msg();
   endtask
   initial begin
      rst_n = 1'b0;
      open_valid = 1'b0;
      del_valid = 1'b0;
      open_req = '0;
      del_req = '0;
      net_up = 1'b0;
      stall = 1'b0;
      delay = 8'd3;
      answer = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_local_deny();
      t_grant_ip();
      t_grant_plain();
      t_delete();
      t_table_full();
      conclude();
   end
endmodule
